// >>> common/rivm_regs.svh
// Constants for the reset and interrupt vector map
`ifndef RIVM_REGS_SVH
`define RIVM_REGS_SVH
`define RIVM_ADDR_W        16
`define RIVM_NUM_SRC       24
`define RIVM_VEC_STEP      16'h0002
`define RIVM_RESET_ADDR    16'h0000
`define RIVM_IRQ_BASE      16'h0002
`define RIVM_ADDR_EXT0     16'h0002
`define RIVM_ADDR_PCG0     16'h0004
`define RIVM_ADDR_PCG1     16'h0006
`define RIVM_ADDR_SPI      16'h0018
`define RIVM_ADDR_USART_RX 16'h001a
`define RIVM_ADDR_USART_DE 16'h001c
`define RIVM_ADDR_USART_TX 16'h001e
`define RIVM_ADDR_EEPROM   16'h0028
`define RIVM_ADDR_SPM      16'h002a
`define RIVM_ADDR_LCD      16'h002c
`define RIVM_ADDR_PCG2     16'h002e
`define RIVM_ADDR_PCG3     16'h0030
`define RIVM_SRC_EXT0      0
`define RIVM_SRC_PCG0      1
`define RIVM_SRC_PCG1      2
`define RIVM_SRC_SPI       11
`define RIVM_SRC_USART_RX  12
`define RIVM_SRC_USART_DE  13
`define RIVM_SRC_USART_TX  14
`define RIVM_SRC_EEPROM    19
`define RIVM_SRC_SPM       20
`define RIVM_SRC_LCD       21
`define RIVM_SRC_PCG2      22
`define RIVM_SRC_PCG3      23
`define RIVM_CTRL_UNLOCK   0
`define RIVM_CTRL_RELOCATE 1
`define RIVM_UNLOCK_CYCLES 3'd4
`define RIVM_FUSE_UNPROG   1'b1
`endif

// >>> common/rivm_pkg.sv
// Types for the reset and interrupt vector map
package rivm_pkg;
  typedef enum logic [1:0] {
    RIVM_S_IDLE   = 2'b00,
    RIVM_S_UNLOCK = 2'b01,
    RIVM_S_TAIL   = 2'b10
  } rivm_block_type;
  typedef logic [15:0] rivm_addr_type;
endpackage

// >>> rtl/rivm_vector_select.sv
// Lowest-index pending source finder
`timescale 1ns/10ps
module rivm_vector_select #(
  parameter int N = 24
) (
  input  wire logic [N-1:0] req,
  output logic              any,
  output logic [4:0]        idx
);
  always_comb begin
    any = 1'b0;
    idx = 5'h00;
    // Scan downward so the lowest index lands last and wins
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 5'(i);
      end
    end
  end
endmodule

// >>> rtl/rivm_top.sv
// Reset and interrupt vector address map with relocation control
//
// Function
// - Every reset source goes to vector one at address 0x0000 while the boot fuse is unprogrammed.
// - External request zero uses vector two at table address 0x0002.
// - Pin-change group zero uses vector three at address 0x0004.
// - Pin-change group one uses vector four at address 0x0006.
// - The serial peripheral transfer-complete event uses vector thirteen at 0x0018.
// - The serial port receive, data-empty and transmit events sit at 0x001A, 0x001C and 0x001E.
// - EEPROM write done, store-program done and display frame start sit at 0x0028, 0x002A, 0x002C.
// - Pin-change groups two and three use vectors twenty-four and twenty-five at 0x002E and 0x0030.
// - Pin-change groups two and three exist only in the larger-package variant.
// - With the boot fuse programmed, the reset address reads 0x0000 during reset and the boot loader reset address from the third clock after it.
// - While relocation is selected each interrupt address is table address plus boot start.
// - Interrupt vectors start at 0x0002, or boot reset address plus 0x0002 when relocated.
// - Fuse value 1 means unprogrammed (reset at zero), 0 means programmed (boot address).
// - The unlock bit clears itself four cycles after being set, or when relocation is written.
// - Interrupts are held off from unlock until after the instruction after the relocate write.
`timescale 1ns/10ps
`include "rivm_regs.svh"
module rivm_top
  import rivm_pkg::*;
#(
  parameter bit HAS_EXTRA_PIN_CHANGE = 1'b1
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     boot_reset_select_fuse,
  input  wire logic [`RIVM_ADDR_W-1:0]  boot_reset_addr,
  input  wire logic [`RIVM_NUM_SRC-1:0] irq_src,
  input  wire logic                     global_int_enable,
  input  wire logic                     ctrl_wr,
  input  wire logic [1:0]               ctrl_wdata,
  input  wire logic                     instr_done,
  output logic [`RIVM_ADDR_W-1:0]       reset_vector_addr,
  output logic                          irq_pending,
  output logic [`RIVM_ADDR_W-1:0]       irq_vector_addr,
  output logic [4:0]                    irq_vector_num,
  output logic                          irq_request,
  output logic                          irq_blocked,
  output logic                          vector_relocate_select,
  output logic                          vector_change_unlock
);

  logic                     fuse_meta_r;
  logic                     fuse_sync_r;
  logic [`RIVM_ADDR_W-1:0]  reset_vector_r;
  logic                     relocate_r;
  logic                     unlock_r;
  logic [2:0]               unlock_cnt_r;
  rivm_block_type           block_r;
  rivm_block_type           block_nxt;
  logic [`RIVM_NUM_SRC-1:0] src_live;
  logic                     sel_any;
  logic [4:0]               sel_idx;
  logic                     pending_r;
  logic [`RIVM_ADDR_W-1:0]  vec_addr_r;
  logic [4:0]               vec_num_r;
  logic                     wr_unlock;
  logic                     wr_relocate;
  logic                     unlock_timeout;
  logic [`RIVM_ADDR_W-1:0]  table_offset;
  logic [`RIVM_ADDR_W-1:0]  irq_base;

  // The fuse is a pin level; synchronise before use
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fuse_meta_r <= `RIVM_FUSE_UNPROG;
      fuse_sync_r <= `RIVM_FUSE_UNPROG;
    end else begin
      fuse_meta_r <= boot_reset_select_fuse;
      fuse_sync_r <= fuse_meta_r;
    end
  end

  // Fuse 1 keeps reset at zero, 0 moves it to the boot loader
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reset_vector_r <= `RIVM_RESET_ADDR;
    end else if (fuse_sync_r == `RIVM_FUSE_UNPROG) begin
      reset_vector_r <= `RIVM_RESET_ADDR;
    end else begin
      reset_vector_r <= boot_reset_addr;
    end
  end

  assign wr_unlock      = ctrl_wr && ctrl_wdata[`RIVM_CTRL_UNLOCK];
  assign wr_relocate    = ctrl_wr && unlock_r && !ctrl_wdata[`RIVM_CTRL_UNLOCK];
  assign unlock_timeout = unlock_r && (unlock_cnt_r == `RIVM_UNLOCK_CYCLES - 3'd1);

  // A new unlock write wins over the self-clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      unlock_r     <= 1'b0;
      unlock_cnt_r <= 3'd0;
    end else if (wr_unlock) begin
      unlock_r     <= 1'b1;
      unlock_cnt_r <= 3'd0;
    end else if (wr_relocate || unlock_timeout) begin
      unlock_r     <= 1'b0;
      unlock_cnt_r <= 3'd0;
    end else if (unlock_r) begin
      unlock_cnt_r <= unlock_cnt_r + 3'd1;
    end
  end

  // Relocation only changes inside the unlock window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      relocate_r <= 1'b0;
    end else if (wr_relocate) begin
      relocate_r <= ctrl_wdata[`RIVM_CTRL_RELOCATE];
    end
  end

  always_comb begin
    block_nxt = block_r;
    case (block_r)
      RIVM_S_IDLE: begin
        block_nxt = RIVM_S_IDLE;
      end
      RIVM_S_UNLOCK: begin
        if (wr_relocate) begin
          block_nxt = RIVM_S_TAIL;
        end else if (unlock_timeout) begin
          block_nxt = RIVM_S_IDLE;
        end
      end
      RIVM_S_TAIL: begin
        if (instr_done) begin
          block_nxt = RIVM_S_IDLE;
        end
      end
      default: begin
        block_nxt = RIVM_S_IDLE;
      end
    endcase
    if (wr_unlock) begin
      block_nxt = RIVM_S_UNLOCK;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      block_r <= RIVM_S_IDLE;
    end else begin
      block_r <= block_nxt;
    end
  end

  // Block starts in the very cycle the unlock is written; global flag untouched
  assign irq_blocked = (block_r != RIVM_S_IDLE) || wr_unlock;

  generate
    if (HAS_EXTRA_PIN_CHANGE) begin : g_extra
      assign src_live = irq_src;
    end else begin : g_small
      // Smaller package has no pin-change groups two and three
      assign src_live = irq_src & ~((`RIVM_NUM_SRC'(1) << `RIVM_SRC_PCG2) |
                                    (`RIVM_NUM_SRC'(1) << `RIVM_SRC_PCG3));
    end
  endgenerate

  rivm_vector_select #(
    .N (`RIVM_NUM_SRC)
  ) u_select (
    .req (src_live),
    .any (sel_any),
    .idx (sel_idx)
  );

  // Source i is vector i+2, so its offset is step times (i+1)
  assign table_offset = `RIVM_ADDR_W'(`RIVM_VEC_STEP * (sel_idx + 5'd1));
  assign irq_base     = relocate_r ? boot_reset_addr : `RIVM_ADDR_W'(0);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pending_r  <= 1'b0;
      vec_addr_r <= `RIVM_IRQ_BASE;
      vec_num_r  <= 5'd0;
    end else begin
      pending_r  <= sel_any;
      vec_addr_r <= irq_base + table_offset;
      vec_num_r  <= sel_idx + 5'd2;
    end
  end

  assign reset_vector_addr      = reset_vector_r;
  assign irq_pending            = pending_r;
  assign irq_vector_addr        = vec_addr_r;
  assign irq_vector_num         = vec_num_r;
  assign irq_request            = pending_r && global_int_enable && !irq_blocked;
  assign vector_relocate_select = relocate_r;
  assign vector_change_unlock   = unlock_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Watch the second sync stage only; the first may be metastable
  AST_RESET_ZERO: assert property (
    fuse_sync_r == `RIVM_FUSE_UNPROG |=> reset_vector_addr == `RIVM_RESET_ADDR)
    else $error("Reset vector not zero with fuse unprogrammed");
  AST_RESET_BOOT: assert property (
    fuse_sync_r == 1'b0 |=> reset_vector_addr == $past(boot_reset_addr))
    else $error("Reset vector not boot address with fuse programmed");
  AST_EXT0_ADDR: assert property (
    src_live[`RIVM_SRC_EXT0] && !relocate_r && !wr_relocate
    |=> irq_vector_addr == `RIVM_ADDR_EXT0 && irq_vector_num == 5'd2)
    else $error("External request zero vector wrong");
  AST_SPI_ADDR: assert property (
    src_live == (`RIVM_NUM_SRC'(1) << `RIVM_SRC_SPI) && !relocate_r && !wr_relocate
    |=> irq_vector_addr == `RIVM_ADDR_SPI)
    else $error("Serial peripheral vector wrong");
  AST_LCD_ADDR: assert property (
    src_live == (`RIVM_NUM_SRC'(1) << `RIVM_SRC_LCD) && !relocate_r && !wr_relocate
    |=> irq_vector_addr == `RIVM_ADDR_LCD)
    else $error("Display frame vector wrong");
  AST_PCG3_ADDR: assert property (
    src_live == (`RIVM_NUM_SRC'(1) << `RIVM_SRC_PCG3) && !relocate_r && !wr_relocate
    |=> irq_vector_addr == `RIVM_ADDR_PCG3)
    else $error("Pin-change group three vector wrong");
  AST_RELOC_BASE: assert property (
    src_live[`RIVM_SRC_EXT0] && relocate_r && !wr_relocate
    |=> irq_vector_addr == $past(boot_reset_addr) + `RIVM_IRQ_BASE)
    else $error("Relocated first vector wrong");
  AST_UNLOCK_TIMEOUT: assert property (
    wr_unlock ##1 (!ctrl_wr) [*4] |=> !vector_change_unlock)
    else $error("Unlock bit not cleared after four cycles");
  AST_UNLOCK_HELD: assert property (
    wr_unlock ##1 (!ctrl_wr) [*4] |-> vector_change_unlock)
    else $error("Unlock bit cleared early");
  AST_BLOCK_TAIL: assert property (
    wr_relocate |-> irq_blocked ##1 (irq_blocked && !irq_request))
    else $error("Interrupts not held after relocate write");
  AST_BLOCK_HOLD: assert property (
    block_r == RIVM_S_TAIL && !instr_done |=> irq_blocked)
    else $error("Hold-off ended before following instruction");
  AST_BLOCK_RELEASE: assert property (
    block_r == RIVM_S_TAIL && instr_done && !wr_unlock |=> !irq_blocked || wr_unlock)
    else $error("Block not released after following instruction");
  AST_PRIORITY: assert property (
    src_live[`RIVM_SRC_EXT0] && src_live[`RIVM_SRC_SPM] |=> irq_vector_num == 5'd2)
    else $error("Lowest vector not chosen first");

  COV_RELOCATE: cover property (wr_relocate && ctrl_wdata[`RIVM_CTRL_RELOCATE]);
  COV_TIMEOUT: cover property (unlock_timeout);
  COV_REQUEST: cover property (irq_request && relocate_r);
  COV_BOOT_RESET: cover property (fuse_sync_r == 1'b0);

endmodule

// >>> bench/rivm_core_model.sv
// Core model: retires instructions and takes offered vectors
`timescale 1ns/10ps
module rivm_core_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [3:0]  gap,
  input  wire logic        irq_request,
  input  wire logic [15:0] irq_vector_addr,
  output logic             instr_done,
  output logic [15:0]      taken_addr
);
  logic [3:0] cnt_r;
  // Larger gap models slow multi-cycle instructions
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r      <= 4'h0;
      instr_done <= 1'b0;
    end else if (run && cnt_r >= gap) begin
      cnt_r      <= 4'h0;
      instr_done <= 1'b1;
    end else begin
      cnt_r      <= cnt_r + 4'h1;
      instr_done <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      taken_addr <= 16'hffff;
    end else if (irq_request) begin
      taken_addr <= irq_vector_addr;
    end
  end
endmodule

// >>> bench/rivm_top_tb.sv
// Self-checking testbench for the vector address map
`timescale 1ns/10ps
module rivm_top_tb;
  logic        clk_sys, rst, fuse, gie, ctrl_wr, run, instr_done;
  logic        pend, req, blocked, reloc, unlock, small_pend;
  logic [1:0]  ctrl_wdata;
  logic [3:0]  gap;
  logic [4:0]  vec_num;
  logic [15:0] boot_addr, rst_addr, vec_addr, taken_addr;
  logic [23:0] irq_src;
  int          err_count, check_count, i;
  int          src_bit[12] = '{0, 1, 2, 11, 12, 13, 14, 19, 20, 21, 22, 23};
  logic [15:0] src_adr[12] = '{16'h0002, 16'h0004, 16'h0006, 16'h0018, 16'h001a, 16'h001c,
                               16'h001e, 16'h0028, 16'h002a, 16'h002c, 16'h002e, 16'h0030};

  rivm_top dut (.clk_sys(clk_sys), .rst(rst), .boot_reset_select_fuse(fuse),
    .boot_reset_addr(boot_addr), .irq_src(irq_src), .global_int_enable(gie),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .instr_done(instr_done),
    .reset_vector_addr(rst_addr), .irq_pending(pend), .irq_vector_addr(vec_addr),
    .irq_vector_num(vec_num), .irq_request(req), .irq_blocked(blocked),
    .vector_relocate_select(reloc), .vector_change_unlock(unlock));
  // Small-package variant sees the same stimulus
  rivm_top #(.HAS_EXTRA_PIN_CHANGE(1'b0)) dut_small (.clk_sys(clk_sys), .rst(rst),
    .boot_reset_select_fuse(fuse), .boot_reset_addr(boot_addr), .irq_src(irq_src),
    .global_int_enable(gie), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .instr_done(instr_done), .reset_vector_addr(), .irq_pending(small_pend),
    .irq_vector_addr(), .irq_vector_num(), .irq_request(), .irq_blocked(),
    .vector_relocate_select(), .vector_change_unlock());
  rivm_core_model core (.clk_sys(clk_sys), .rst(rst), .run(run), .gap(gap),
    .irq_request(req), .irq_vector_addr(vec_addr), .instr_done(instr_done),
    .taken_addr(taken_addr));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk16({15'h0, got}, {15'h0, exp}, what);
  endtask
  task automatic cw(input logic [1:0] d);
    @(posedge clk_sys);
    ctrl_wr    <= 1'b1;
    ctrl_wdata <= d;
    @(posedge clk_sys);
    ctrl_wr <= 1'b0;
    #1;
  endtask
  task automatic raise(input logic [23:0] s);
    @(posedge clk_sys);
    irq_src <= s;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end

  initial begin
    rst = 1'b1; fuse = 1'b1; gie = 1'b1; ctrl_wr = 1'b0; ctrl_wdata = 2'b00;
    boot_addr = 16'h3800; irq_src = 24'h0; run = 1'b0; gap = 4'd2;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk16(rst_addr, 16'h0000, "reset vector unprogrammed");
    @(posedge clk_sys);
    fuse <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk16(rst_addr, boot_addr, "reset vector programmed");
    $display("test reset vector done");
    for (i = 0; i < 12; i++) begin
      raise(24'h1 << src_bit[i]);
      chk16(vec_addr, src_adr[i], "vector address");
      chk16({11'h0, vec_num}, (src_adr[i] >> 1) + 16'h1, "vector number");
    end
    raise(24'hc00000);
    chk1(small_pend, 1'b0, "variant pin change");
    chk1(pend, 1'b1, "full pin change");
    raise(24'h801800);
    chk16(vec_addr, 16'h0018, "priority");
    $display("test vector table done");
    raise(24'h000001);
    cw(2'b01);
    chk1(unlock, 1'b1, "unlock set");
    chk1(req, 1'b0, "held off");
    repeat (3) @(posedge clk_sys);
    #1;
    chk1(unlock, 1'b1, "unlock still set");
    @(posedge clk_sys);
    #1;
    chk1(unlock, 1'b0, "unlock expired");
    chk1(reloc, 1'b0, "no relocate");
    chk1(req, 1'b1, "released");
    $display("test unlock timeout done");
    cw(2'b01);
    cw(2'b10);
    chk1(reloc, 1'b1, "relocated");
    chk1(unlock, 1'b0, "unlock cleared by write");
    chk1(blocked, 1'b1, "tail hold-off");
    @(posedge clk_sys);
    run <= 1'b1;
    for (i = 0; i < 20 && blocked !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk1(blocked, 1'b0, "hold-off ended");
    chk1(req, 1'b1, "request with flag kept");
    chk16(vec_addr, 16'h3802, "relocated base");
    raise(24'h200000);
    @(posedge clk_sys);
    #1;
    chk16(taken_addr, 16'h382c, "relocated vector taken");
    chk16(rst_addr, boot_addr, "reset vector kept");
    @(posedge clk_sys);
    gie <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk1(req, 1'b0, "flag clear masks request");
    chk1(pend, 1'b1, "pending kept with flag clear");
    $display("test relocate done");
    end_sim();
  end
endmodule
